// >>> design/motion_pkg.sv
/*
  Shared constants and types of the drive command front end: speeds,
  ramp timing, status bit positions, configuration and copy carriers.
  Assumes a 200 MHz system clock and speeds in whole rpm.
*/
package motion_pkg;
  localparam int SPD_W = 16;
  typedef logic signed [SPD_W-1:0] speed_t;

  localparam longint CLK_HZ = 200_000_000;
  localparam longint MAX_SPEED_RPM = 1500;
  localparam longint RAMP_UP_S = 10;
  localparam longint RAMP_DOWN_S = 10;
  localparam longint QUICK_STOP_MS = 1000;
  localparam longint CMD_SET_SWITCH_MS = 4;
  // Cycles per 1 rpm step, ramp time referred to the maximum speed
  localparam int RAMP_UP_CYC = int'((RAMP_UP_S * CLK_HZ) / MAX_SPEED_RPM);
  localparam int RAMP_DOWN_CYC =
    int'((RAMP_DOWN_S * CLK_HZ) / MAX_SPEED_RPM);
  localparam int QUICK_STOP_CYC =
    int'((QUICK_STOP_MS * CLK_HZ) / (1000 * MAX_SPEED_RPM));
  localparam int CMD_SET_SWITCH_CYC =
    int'((CMD_SET_SWITCH_MS * CLK_HZ) / 1000);
  localparam int COPY_CYC = 16;

  localparam speed_t JOG_ONE_RST = 16'h0096;
  localparam speed_t JOG_TWO_RST = 16'hff6a;
  localparam speed_t MAX_SPEED_RST = 16'h05dc;
  localparam logic [2:0] CMD_SET_COUNT_RST = 3'h2;
  localparam logic [2:0] CMD_SET_COUNT_MIN = 3'h2;
  localparam logic [2:0] CMD_SET_COUNT_MAX = 3'h4;
  localparam logic [7:0] FILTER_COMMISSION = 8'h0f;

  localparam int ST_ON = 0;
  localparam int ST_NO_QSTOP = 1;
  localparam int ST_STANDSTILL = 2;
  localparam int ST_PLUS = 4;
  localparam int ST_MINUS = 5;

  typedef struct packed {
    speed_t jog_one_speed;
    speed_t jog_two_speed;
    speed_t max_speed_limit;
    logic neg_dir_inhibit;
    logic pos_dir_inhibit;
    logic setpoint_invert;
  } cfg_s;

  localparam cfg_s CFG_RST = '{JOG_ONE_RST, JOG_TWO_RST, MAX_SPEED_RST,
                               1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] tgt;
  } copy_req_s;

  typedef enum logic [1:0] {LIM_IDLE, LIM_MOVE, LIM_STOP} lim_state_e;
endpackage

// >>> design/ramp_gen.sv
/*
  Ramp generator: moves the output speed one rpm per step toward the
  target. Assumes target held steady by the caller between changes.
*/
`timescale 1ns/1ps
`default_nettype none
module ramp_gen
  import motion_pkg::*;
#(
  parameter int UP_CYC = RAMP_UP_CYC,
  parameter int DOWN_CYC = RAMP_DOWN_CYC,
  parameter int QUICK_CYC = QUICK_STOP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire speed_t target,
  input wire logic quick,
  output speed_t speed_q
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] period;
  logic away;
  logic up;
  logic step;
  speed_t speed_d;

  assign up = target > speed_q;
  assign away = (up && speed_q >= 0) || (!up && speed_q <= 0);
  assign period = quick ? 32'(QUICK_CYC) :
                  (away ? 32'(UP_CYC) : 32'(DOWN_CYC));
  assign step = (target != speed_q) && (cnt_q >= period - 32'h0000_0001);
  assign cnt_d = (target == speed_q || step) ? '0 : cnt_q + 32'h0000_0001;
  assign speed_d = !step ? speed_q :
                   (up ? speed_q + 16'sh0001 : speed_q - 16'sh0001);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      speed_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      speed_q <= speed_d;
    end
  end
endmodule
`default_nettype wire

// >>> design/drive_motion_command_front_end.sv
/*
  Command front end of a motor drive: jogging, limit position control
  and command data set selection and copying. Assumes all inputs are
  synchronous to clk_sys and speeds are signed rpm.
*/
// How it works
// - Jog accepted only when ready to switch on
// - Jog on ramps to setpoint; release stops
// - Jog speeds default +150 and -150 rpm
// - Jog uses the common ramp, 10 s
// - Maximum speed bounds setpoint, default 1500
// - Negative inhibit blocks negative rotation
// - Positive inhibit blocks positive rotation
// - Inversion negates the speed setpoint
// - Jog bits come from inputs 0, 1
// - Limit reached stops with quick ramp
// - At a limit, next move goes opposite
// - Motion starts only on start rising edge
// - No limit active: setpoint sign picks direction
// - Status word: on, no-quick-stop, standstill, limits
// - Two select bits choose command data set
// - Data set count two to four, default two
// - Copy source, target, start; device clears start
// - Active data set number is readable
// - Data set switch takes about 4 ms
`timescale 1ns/1ps
`default_nettype none
module drive_motion_command_front_end
  import motion_pkg::*;
#(
  parameter int UP_CYC = RAMP_UP_CYC,
  parameter int DOWN_CYC = RAMP_DOWN_CYC,
  parameter int QUICK_CYC = QUICK_STOP_CYC,
  parameter int SWITCH_CYC = CMD_SET_SWITCH_CYC,
  parameter int COPY_LEN = COPY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ready_to_switch_on,
  input wire logic [1:0] jog_select,
  input wire cfg_s cfg_in,
  input wire logic cfg_we,
  input wire logic [7:0] commissioning_filter,
  input wire logic [2:0] cmd_set_count_in,
  input wire logic cmd_set_count_we,
  input wire speed_t speed_setpoint,
  input wire logic limit_ctrl_en,
  input wire logic limit_start_input,
  input wire logic minus_limit_input_n,
  input wire logic plus_limit_input_n,
  input wire logic cmd_set_select_bit0,
  input wire logic cmd_set_select_bit1,
  input wire copy_req_s copy_in,
  input wire logic copy_start_we,
  output speed_t speed_out,
  output logic motor_on,
  output logic [7:0] limit_status_word,
  output logic [1:0] active_cmd_set,
  output logic cmd_set_copy_ctrl,
  output copy_req_s copy_req,
  output logic [2:0] cmd_set_count
);
  cfg_s cfg_q;
  logic jog_run_q;
  logic jog_two_q;
  logic start_q;
  logic dir_neg_q;
  lim_state_e lim_q;
  lim_state_e lim_d;
  logic motor_on_q;
  logic [7:0] status_q;
  logic [1:0] active_q;
  logic [1:0] pending_q;
  logic [31:0] sw_cnt_q;
  logic copy_busy_q;
  logic [31:0] copy_cnt_q;
  copy_req_s copy_q;
  logic [2:0] count_q;

  // Jog bit 0 wired from digital input 0, bit 1 from input 1
  wire jog_req = |jog_select;
  wire jog_start = jog_req && ready_to_switch_on && !jog_run_q;
  wire start_rise = limit_start_input && !start_q;
  wire plus_act = !plus_limit_input_n;
  wire minus_act = !minus_limit_input_n;
  wire speed_zero = speed_out == '0;

  // Direction for a new limit motion
  wire new_dir_neg = plus_act ? 1'b1 :
                     (minus_act ? 1'b0 : speed_setpoint < 0);
  wire new_blocked = new_dir_neg ? minus_act : plus_act;
  wire at_target = dir_neg_q ? minus_act : plus_act;
  wire lim_go = limit_ctrl_en && start_rise && !new_blocked &&
                !jog_run_q;

  always_comb begin
    lim_d = lim_q;
    unique case (lim_q)
      LIM_IDLE: begin
        if (lim_go) begin
          lim_d = LIM_MOVE;
        end
      end
      LIM_MOVE: begin
        if (at_target) begin
          lim_d = LIM_STOP;
        end else if (!limit_ctrl_en) begin
          lim_d = LIM_IDLE;
        end
      end
      LIM_STOP: begin
        if (speed_zero) begin
          lim_d = LIM_IDLE;
        end
      end
    endcase
  end

  // Setpoint path: select, invert, inhibit, clamp
  speed_t sp_mag;
  speed_t raw;
  speed_t inv;
  speed_t tgt;
  speed_t neg_max;
  assign sp_mag = speed_setpoint < 0 ? -speed_setpoint : speed_setpoint;
  assign raw = jog_run_q ?
               (jog_two_q ? cfg_q.jog_two_speed : cfg_q.jog_one_speed) :
               (lim_q == LIM_MOVE ? (dir_neg_q ? -sp_mag : sp_mag) : '0);
  assign inv = cfg_q.setpoint_invert ? -raw : raw;
  assign neg_max = -cfg_q.max_speed_limit;
  assign tgt = (inv < 0 && cfg_q.neg_dir_inhibit) ? '0 :
               (inv > 0 && cfg_q.pos_dir_inhibit) ? '0 :
               (inv > cfg_q.max_speed_limit) ? cfg_q.max_speed_limit :
               (inv < neg_max) ? neg_max : inv;

  // Jog and limit motion share the normal ramp
  ramp_gen #(
    .UP_CYC(UP_CYC),
    .DOWN_CYC(DOWN_CYC),
    .QUICK_CYC(QUICK_CYC)
  ) u_ramp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .target(tgt),
    .quick(lim_q == LIM_STOP),
    .speed_q(speed_out)
  );

  // Command data set index and clamp
  wire [1:0] req_idx = {cmd_set_select_bit1, cmd_set_select_bit0};
  wire [1:0] max_idx = 2'(count_q - 3'h1);
  wire [1:0] sel_idx = req_idx > max_idx ? max_idx : req_idx;
  wire sw_done = sw_cnt_q >= 32'(SWITCH_CYC) - 32'h0000_0001;
  wire count_ok = cmd_set_count_we &&
                  commissioning_filter == FILTER_COMMISSION &&
                  cmd_set_count_in >= CMD_SET_COUNT_MIN &&
                  cmd_set_count_in <= CMD_SET_COUNT_MAX;
  wire copy_done = copy_busy_q &&
                   copy_cnt_q >= 32'(COPY_LEN) - 32'h0000_0001;

  wire [7:0] status_d = {2'b00, minus_act, plus_act, 1'b0,
                         speed_zero, lim_d != LIM_STOP, lim_d == LIM_MOVE};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RST;
      count_q <= CMD_SET_COUNT_RST;
    end else begin
      if (cfg_we) begin
        cfg_q <= cfg_in;
      end
      if (count_ok) begin
        count_q <= cmd_set_count_in;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jog_run_q <= 1'b0;
      jog_two_q <= 1'b0;
      start_q <= 1'b0;
      dir_neg_q <= 1'b0;
      lim_q <= LIM_IDLE;
      motor_on_q <= 1'b0;
      status_q <= '0;
    end else begin
      start_q <= limit_start_input;
      lim_q <= lim_d;
      status_q <= status_d;
      if (!jog_req) begin
        jog_run_q <= 1'b0;
      end else if (jog_start && lim_q == LIM_IDLE) begin
        jog_run_q <= 1'b1;
        jog_two_q <= !jog_select[0];
      end
      if (lim_q == LIM_IDLE && lim_go) begin
        dir_neg_q <= new_dir_neg;
      end
      motor_on_q <= jog_run_q || lim_q == LIM_MOVE || !speed_zero;
    end
  end

  // Data set switch delay and copy sequence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= '0;
      pending_q <= '0;
      sw_cnt_q <= '0;
      copy_busy_q <= 1'b0;
      copy_cnt_q <= '0;
      copy_q <= '0;
    end else begin
      pending_q <= sel_idx;
      if (sel_idx != pending_q || sel_idx == active_q) begin
        sw_cnt_q <= '0;
      end else if (sw_done) begin
        active_q <= sel_idx;
        sw_cnt_q <= '0;
      end else begin
        sw_cnt_q <= sw_cnt_q + 32'h0000_0001;
      end
      if (copy_start_we) begin
        copy_busy_q <= 1'b1;
        copy_q <= copy_in;
        copy_cnt_q <= '0;
      end else if (copy_done) begin
        copy_busy_q <= 1'b0;
      end else if (copy_busy_q) begin
        copy_cnt_q <= copy_cnt_q + 32'h0000_0001;
      end
    end
  end

  assign motor_on = motor_on_q;
  assign limit_status_word = status_q;
  assign active_cmd_set = active_q;
  assign cmd_set_copy_ctrl = copy_busy_q;
  assign copy_req = copy_q;
  assign cmd_set_count = count_q;

  // Checks
  property p_jog_ready;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(jog_run_q) |-> $past(ready_to_switch_on);
  endproperty
  a_jog_ready: assert property (p_jog_ready)
    else $error("Jog started outside ready state");

  property p_jog_release;
    @(posedge clk_sys) disable iff (!rst_n)
      !jog_req |=> !jog_run_q;
  endproperty
  a_jog_release: assert property (p_jog_release)
    else $error("Jog still running after release");

  property p_max;
    @(posedge clk_sys) disable iff (!rst_n)
      tgt <= cfg_q.max_speed_limit && tgt >= neg_max;
  endproperty
  a_max: assert property (p_max)
    else $error("Setpoint exceeds maximum speed");

  property p_neg_inh;
    @(posedge clk_sys) disable iff (!rst_n)
      cfg_q.neg_dir_inhibit |-> tgt >= 0;
  endproperty
  a_neg_inh: assert property (p_neg_inh)
    else $error("Negative rotation not inhibited");

  property p_pos_inh;
    @(posedge clk_sys) disable iff (!rst_n)
      cfg_q.pos_dir_inhibit |-> tgt <= 0;
  endproperty
  a_pos_inh: assert property (p_pos_inh)
    else $error("Positive rotation not inhibited");

  property p_invert;
    @(posedge clk_sys) disable iff (!rst_n)
      jog_run_q && !jog_two_q && cfg_q.setpoint_invert &&
      !cfg_q.pos_dir_inhibit && !cfg_q.neg_dir_inhibit &&
      cfg_q.jog_one_speed >= 0 &&
      cfg_q.jog_one_speed <= cfg_q.max_speed_limit
      |-> tgt == -cfg_q.jog_one_speed;
  endproperty
  a_invert: assert property (p_invert)
    else $error("Inverted setpoint wrong");

  property p_start_edge;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(lim_q == LIM_MOVE) |-> $past(start_rise);
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("Motion began without start edge");

  property p_limit_stop;
    @(posedge clk_sys) disable iff (!rst_n)
      lim_q == LIM_MOVE && at_target |=> lim_q == LIM_STOP && tgt == '0;
  endproperty
  a_limit_stop: assert property (p_limit_stop)
    else $error("No quick stop at limit");

  property p_status;
    @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> limit_status_word[ST_PLUS] == $past(plus_act) &&
               limit_status_word[ST_MINUS] == $past(minus_act);
  endproperty
  a_status: assert property (p_status)
    else $error("Limit status bits wrong");

  // Cycles an out-of-range active set waits on a steady selection
  logic [31:0] over_cnt_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      over_cnt_q <= '0;
    end else if (active_q > max_idx && sel_idx == pending_q) begin
      over_cnt_q <= over_cnt_q + 32'h0000_0001;
    end else begin
      over_cnt_q <= '0;
    end
  end

  // Lowered count must pull the active set in within one switch time
  property p_clamp;
    @(posedge clk_sys) disable iff (!rst_n)
      over_cnt_q <= 32'(SWITCH_CYC);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("Active data set beyond count");

  property p_copy;
    @(posedge clk_sys) disable iff (!rst_n)
      copy_start_we |=> cmd_set_copy_ctrl ##[1:1000] !cmd_set_copy_ctrl;
  endproperty
  a_copy: assert property (p_copy)
    else $error("Copy start not cleared");

  c_jog: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(jog_run_q));
  c_limit: cover property (@(posedge clk_sys) disable iff (!rst_n)
    lim_q == LIM_MOVE ##1 lim_q == LIM_STOP);
  c_switch: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(active_q));
endmodule
`default_nettype wire

// >>> testbench/machine_model.sv
/*
  Machine model: integrates motor speed into a position and drives
  the two active-low limit switches from it.
  Assumes speed_out in rpm, sampled on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module machine_model
  import motion_pkg::*;
#(
  parameter int PLIM = 20000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire speed_t speed_out,
  output logic plus_limit_input_n,
  output logic minus_limit_input_n
);
  int pos_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 0;
    end else begin
      pos_q <= pos_q + int'(speed_out);
    end
  end
  // Switch pulls low while actuated
  assign plus_limit_input_n = !(pos_q >= PLIM);
  assign minus_limit_input_n = !(pos_q <= -PLIM);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
/*
  Self-checking bench of the command front end with a machine model.
  Assumes shortened ramp, switch and copy counts.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin mismatches++; $display("FAIL %0t %h %h", $time, g, x); end end
module tb_top;
  import motion_pkg::*;
  localparam int UP = 4, DN = 4, QK = 2, SW = 8, CP = 4;
  logic clk_sys = 0;
  logic rst_n = 0;
  logic ready = 0, lim_en = 0, start = 0, cfg_we = 0, cnt_we = 0;
  logic cp_we = 0, sb0 = 0, sb1 = 0;
  logic [1:0] jog = 0;
  logic [7:0] filt = 0;
  logic [2:0] cnt_in = 3'h2;
  cfg_s cfg = CFG_RST;
  speed_t sp = 0;
  copy_req_s cp_in = 0;
  wire logic plus_n, minus_n;
  speed_t spd;
  logic mon, cctl;
  logic [7:0] stat;
  logic [1:0] act;
  copy_req_s creq;
  logic [2:0] cnt;
  int mismatches = 0, cmp_count = 0;
  int n, a, e, s;

  always #2.5 clk_sys = ~clk_sys;

  drive_motion_command_front_end #(.UP_CYC(UP), .DOWN_CYC(DN),
    .QUICK_CYC(QK), .SWITCH_CYC(SW), .COPY_LEN(CP)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .ready_to_switch_on(ready),
    .jog_select(jog), .cfg_in(cfg), .cfg_we(cfg_we),
    .commissioning_filter(filt), .cmd_set_count_in(cnt_in),
    .cmd_set_count_we(cnt_we), .speed_setpoint(sp),
    .limit_ctrl_en(lim_en), .limit_start_input(start),
    .minus_limit_input_n(minus_n), .plus_limit_input_n(plus_n),
    .cmd_set_select_bit0(sb0), .cmd_set_select_bit1(sb1),
    .copy_in(cp_in), .copy_start_we(cp_we), .speed_out(spd),
    .motor_on(mon), .limit_status_word(stat), .active_cmd_set(act),
    .cmd_set_copy_ctrl(cctl), .copy_req(creq), .cmd_set_count(cnt));

  // Position only tracked while limit control runs
  machine_model mm_u (.clk_sys(clk_sys), .rst_n(rst_n && lim_en),
    .speed_out(spd), .plus_limit_input_n(plus_n),
    .minus_limit_input_n(minus_n));

  task automatic step(int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic wcnt(logic [7:0] f, logic [2:0] v);
    step(1);
    filt <= f;
    cnt_in <= v;
    cnt_we <= 1;
    step(1);
    cnt_we <= 0;
    filt <= 0;
  endtask

  function automatic int jexp(logic [1:0] j, cfg_s c);
    int v;
    v = j[0] ? int'(c.jog_one_speed) : int'(c.jog_two_speed);
    if (c.setpoint_invert) v = -v;
    if (v > int'(c.max_speed_limit)) v = int'(c.max_speed_limit);
    if (v < -int'(c.max_speed_limit)) v = -int'(c.max_speed_limit);
    if (c.neg_dir_inhibit && v < 0) v = 0;
    if (c.pos_dir_inhibit && v > 0) v = 0;
    return v;
  endfunction

  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end

  initial begin
    cfg_s c;
    logic [4:0] cs [6];
    void'($urandom(38));
    cs = '{5'b00001, 5'b00110, 5'b10010, 5'b01001, 5'b01110, 5'b00011};
    step(2);
    rst_n <= 1;
    step(1);
    #1;
    `CHK(spd, 16'h0000)
    `CHK(mon, 1'b0)
    `CHK(act, 2'h0)
    `CHK(cctl, 1'b0)
    `CHK(cnt, 3'h2)
    `CHK(stat, 8'h06)
    wcnt(8'h00, 3'h4);
    #1;
    `CHK(cnt, 3'h2)
    wcnt(8'h0f, 3'h5);
    #1;
    `CHK(cnt, 3'h2)
    s = 0;
    for (int k = 0; k < 6; k++) begin
      a = 2 + $urandom % 3;
      wcnt(8'h0f, 3'(a));
      #1;
      `CHK(cnt, 3'(a))
      step(SW + 3);
      e = (s > a - 1) ? a - 1 : s;
      s = $urandom % 4;
      sb0 <= s[0];
      sb1 <= s[1];
      step(2);
      #1;
      `CHK(act, 2'(e))
      step(SW + 2);
      #1;
      `CHK(act, 2'((s > a - 1) ? a - 1 : s))
    end
    step(1);
    cp_in <= 4'($urandom);
    cp_we <= 1;
    step(1);
    cp_we <= 0;
    #1;
    `CHK(cctl, 1'b1)
    `CHK(creq, cp_in)
    step(CP - 1);
    #1;
    `CHK(cctl, 1'b1)
    step(1);
    #1;
    `CHK(cctl, 1'b0)
    step(1);
    lim_en <= 1;
    sp <= 16'h0028;
    step(1);
    start <= 1;
    step(3);
    #1;
    `CHK(stat[0], 1'b1)
    step(20);
    #1;
    `CHK(spd > 0, 1'b1)
    for (n = 0; n < 5000 && stat[4] !== 1'b1; n++) step(1);
    #1;
    `CHK(stat[2:0], 3'b000)
    for (a = 0; a < 500 && spd !== 0; a++) step(1);
    #1;
    `CHK(a <= 40 * QK + 4, 1'b1)
    step(2);
    #1;
    `CHK({stat[5], stat[4], stat[2]}, 3'b011)
    step(30);
    #1;
    `CHK(spd, 16'h0000)
    step(1);
    start <= 0;
    step(2);
    start <= 1;
    for (n = 0; n < 40 && !(spd < 0); n++) step(1);
    #1;
    `CHK(spd < 0, 1'b1)
    for (n = 0; n < 6000 && stat[5] !== 1'b1; n++) step(1);
    #1;
    `CHK(stat[5], 1'b1)
    for (n = 0; n < 500 && spd !== 0; n++) step(1);
    lim_en <= 0;
    start <= 0;
    jog <= 2'b01;
    step(20);
    #1;
    `CHK(mon, 1'b0)
    `CHK(spd, 16'h0000)
    step(1);
    ready <= 1;
    step(20);
    #1;
    a = int'(spd);
    step(40);
    #1;
    `CHK(int'(spd) - a, 40 / UP)
    `CHK(mon, 1'b1)
    for (n = 0; n < 1000 && spd !== 16'h0096; n++) step(1);
    #1;
    `CHK(spd, 16'h0096)
    step(1);
    jog <= 0;
    for (n = 0; n < 2000 && (spd !== 0 || mon !== 0); n++) step(1);
    #1;
    `CHK(mon, 1'b0)
    for (int k = 0; k < 6; k++) begin
      c = CFG_RST;
      c.jog_one_speed = speed_t'(10 + $urandom % 200);
      c.jog_two_speed = speed_t'(-(10 + $urandom % 200));
      c.max_speed_limit = speed_t'(50 + $urandom % 150);
      {c.neg_dir_inhibit, c.pos_dir_inhibit, c.setpoint_invert} = cs[k][4:2];
      step(1);
      cfg <= c;
      cfg_we <= 1;
      step(1);
      cfg_we <= 0;
      e = jexp(cs[k][1:0], c);
      jog <= cs[k][1:0];
      for (n = 0; n < 2000 && int'(spd) !== e; n++) step(1);
      step(10);
      #1;
      `CHK(spd, speed_t'(e))
      `CHK(mon, 1'b1)
      step(1);
      jog <= 0;
      for (n = 0; n < 2000 && (spd !== 0 || mon !== 0); n++) step(1);
      #1;
      `CHK(mon, 1'b0)
    end
    step(1);
    lim_en <= 1;
    sp <= 16'hffd8;
    step(1);
    start <= 1;
    step(20);
    #1;
    `CHK(spd < 0, 1'b1)
    `CHK(stat[0], 1'b1)
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
